// file: hw/rmis_defines.svh
`ifndef RMIS_DEFINES_SVH
`define RMIS_DEFINES_SVH

// register word indices (byte address = index * 4)
`define RMIS_MAP_FIRST_IDX 6'h00
`define RMIS_MAP_COUNT 34
`define RMIS_LOCK_CTL_IDX 6'h22
`define RMIS_KEY_IDX 6'h23
`define RMIS_LOCK_BIT 11
`define RMIS_KEY_FIRST 8'h55
`define RMIS_KEY_SECOND 8'hAA
`define RMIS_MAP_RESET 16'h0000

// selector codes
`define RMIS_SEL_LOW 8'h00
`define RMIS_SEL_CMP_FIRST 8'h01
`define RMIS_SEL_CMP_LAST 8'h03
`define RMIS_SEL_TRIG_FIRST 8'h06
`define RMIS_SEL_TRIG_LAST 8'h07
`define RMIS_SEL_PWM_FIRST 8'h0B
`define RMIS_SEL_PWM_LAST 8'h0D
`define RMIS_SEL_PB_FIRST 8'h20
`define RMIS_SEL_PB_LAST 8'h2F
`define RMIS_SEL_PC_FIRST 8'h30
`define RMIS_SEL_PC_LAST 8'h3D
`define RMIS_SEL_PD1 8'h41
`define RMIS_SEL_PD8 8'h48
`define RMIS_SEL_PD10 8'h4A
`define RMIS_SEL_PD13 8'h4D
`define RMIS_SEL_VP_FIRST 8'hB0
`define RMIS_SEL_VP_LAST 8'hB5

`endif

// file: hw/rmis_pkg.sv
package rmis_pkg;
   // internal source group
   typedef struct packed {
      logic [2:0] cmp;
      logic [1:0] trig;
      logic [2:0] pwm_evt;
   } rmis_int_src_s;

   // physical pin group, already gated by direction
   typedef struct packed {
      logic [15:0] port_b;
      logic [13:0] port_c;
      logic [3:0] port_d;
   } rmis_pins_s;

   typedef enum logic [1:0] {
      RMIS_KEY_IDLE = 2'b00,
      RMIS_KEY_HALF = 2'b01,
      RMIS_KEY_OPEN = 2'b10
   } rmis_key_e;
endpackage

// file: hw/rmis_sel_mux.sv
`timescale 1ns/10ps
`include "rmis_defines.svh"

// one registered selector: 8-bit code to one peripheral input
module rmis_sel_mux (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] sel_i,
   input wire rmis_pkg::rmis_int_src_s int_i,
   input wire rmis_pkg::rmis_pins_s pins_i,
   input wire logic [5:0] vpin_i,
   output logic out_o
);
   logic src_d;

   always_comb begin
      src_d = 1'b0;
      if (sel_i >= `RMIS_SEL_CMP_FIRST && sel_i <= `RMIS_SEL_CMP_LAST) begin
         src_d = int_i.cmp[2'(sel_i - `RMIS_SEL_CMP_FIRST)];
      end else if (sel_i >= `RMIS_SEL_TRIG_FIRST && sel_i <= `RMIS_SEL_TRIG_LAST) begin
         src_d = int_i.trig[1'(sel_i - `RMIS_SEL_TRIG_FIRST)];
      end else if (sel_i >= `RMIS_SEL_PWM_FIRST && sel_i <= `RMIS_SEL_PWM_LAST) begin
         src_d = int_i.pwm_evt[2'(sel_i - `RMIS_SEL_PWM_FIRST)];
      end else if (sel_i >= `RMIS_SEL_PB_FIRST && sel_i <= `RMIS_SEL_PB_LAST) begin
         src_d = pins_i.port_b[4'(sel_i - `RMIS_SEL_PB_FIRST)];
      end else if (sel_i >= `RMIS_SEL_PC_FIRST && sel_i <= `RMIS_SEL_PC_LAST) begin
         src_d = pins_i.port_c[4'(sel_i - `RMIS_SEL_PC_FIRST)];
      end else if (sel_i == `RMIS_SEL_PD1) begin
         src_d = pins_i.port_d[0];
      end else if (sel_i == `RMIS_SEL_PD8) begin
         src_d = pins_i.port_d[1];
      end else if (sel_i == `RMIS_SEL_PD10) begin
         src_d = pins_i.port_d[2];
      end else if (sel_i == `RMIS_SEL_PD13) begin
         src_d = pins_i.port_d[3];
      end else if (sel_i >= `RMIS_SEL_VP_FIRST && sel_i <= `RMIS_SEL_VP_LAST) begin
         src_d = vpin_i[3'(sel_i - `RMIS_SEL_VP_FIRST)];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_o <= 1'b0;
      end else begin
         out_o <= src_d;
      end
   end
endmodule // rmis_sel_mux

// file: hw/rmis_top.sv
`timescale 1ns/10ps
`include "rmis_defines.svh"

// What this block does
// - a pin feeds a peripheral only while its direction bit says input.
// - physical pin codes reach only pins 32 to 77.
// - low codes: 0 low, 1-3 comparators, 6-7 triggers, 11-13 pwm events.
// - 32-47 port B, 48-61 port C, 65/72/74/77 port D bits.
// - codes 176 to 181 select six internal virtual pins.
// - virtual pins are selected like physical pins for input mapping, but are not gated by direction bits.
// - output routed to a virtual pin reaches inputs selecting it.
// - each remappable input has its own 8-bit selector field.
// - adc trigger selector shares a register with logic cell input d.
// - writing a selector field connects that source to the input.
// - lock set makes map writes complete but change nothing; clear at reset.

module rmis_top #(
   parameter int NUM_MAPS = `RMIS_MAP_COUNT
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone classic slave
   input wire logic [7:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [3:0] sel_i,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // sources
   input wire rmis_pkg::rmis_pins_s pin_level_i,
   input wire rmis_pkg::rmis_pins_s pin_direction_bits_i,
   input wire rmis_pkg::rmis_int_src_s int_src_i,
   input wire logic [5:0] virtual_pin_drive_i,
   // one output per selector field, field 2k is low byte of register k
   output logic [2*NUM_MAPS-1:0] periph_in_o,
   output logic map_write_lock_o
);
   initial begin
      if (NUM_MAPS < 1 || NUM_MAPS > 34) begin
         $error("NUM_MAPS out of range");
      end
   end

   // ---------------------------------------------------------------
   // register bus
   // ---------------------------------------------------------------
   logic [15:0] map_q [NUM_MAPS];
   logic lock_q;
   rmis_pkg::rmis_key_e key_q;
   logic [5:0] idx;
   logic req;
   logic wr;

   assign idx = adr_i[7:2];
   assign req = cyc_i && stb_i && !ack_o;
   assign wr = req && we_i;

   // one-cycle answer; unmapped reads return zero, writes ignored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= req;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (req && !we_i) begin
         dat_o <= 32'h0000_0000;
         if (idx < 6'(NUM_MAPS)) begin
            dat_o <= {16'h0000, map_q[idx[5:0]]};
         end else if (idx == `RMIS_LOCK_CTL_IDX) begin
            dat_o[`RMIS_LOCK_BIT] <= lock_q;
         end else if (idx == `RMIS_KEY_IDX) begin
            dat_o[1:0] <= key_q;
         end
      end
   end

   // ---------------------------------------------------------------
   // selector fields
   // ---------------------------------------------------------------
   // lock writes are silently dropped but still acked
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NUM_MAPS; i++) begin
            map_q[i] <= `RMIS_MAP_RESET;
         end
      end else if (wr && !lock_q && idx < 6'(NUM_MAPS)) begin
         if (sel_i[0]) begin
            map_q[idx][7:0] <= dat_i[7:0];
         end
         if (sel_i[1]) begin
            map_q[idx][15:8] <= dat_i[15:8];
         end
      end
   end

   // ---------------------------------------------------------------
   // unlock key sequence and lock bit
   // ---------------------------------------------------------------
   // any other bus write breaks the sequence, so stray traffic cannot unlock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         key_q <= rmis_pkg::RMIS_KEY_IDLE;
      end else if (wr) begin
         unique case (key_q)
            rmis_pkg::RMIS_KEY_IDLE: begin
               if (idx == `RMIS_KEY_IDX && sel_i[0] && dat_i[7:0] == `RMIS_KEY_FIRST) begin
                  key_q <= rmis_pkg::RMIS_KEY_HALF;
               end
            end
            rmis_pkg::RMIS_KEY_HALF: begin
               if (idx == `RMIS_KEY_IDX && sel_i[0] && dat_i[7:0] == `RMIS_KEY_SECOND) begin
                  key_q <= rmis_pkg::RMIS_KEY_OPEN;
               end else begin
                  key_q <= rmis_pkg::RMIS_KEY_IDLE;
               end
            end
            rmis_pkg::RMIS_KEY_OPEN: begin
               key_q <= rmis_pkg::RMIS_KEY_IDLE;
            end
            default: begin
               key_q <= rmis_pkg::RMIS_KEY_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_q <= 1'b0;
      end else if (wr && key_q == rmis_pkg::RMIS_KEY_OPEN && idx == `RMIS_LOCK_CTL_IDX && sel_i[1]) begin
         lock_q <= dat_i[`RMIS_LOCK_BIT];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         map_write_lock_o <= 1'b0;
      end else begin
         map_write_lock_o <= lock_q;
      end
   end

   // ---------------------------------------------------------------
   // source gating and muxes
   // ---------------------------------------------------------------
   rmis_pkg::rmis_pins_s pins_in;

   // an output-direction pin never reaches a peripheral input
   assign pins_in = pin_level_i & pin_direction_bits_i;

   for (genvar g = 0; g < 2 * NUM_MAPS; g++) begin : g_sel
      rmis_sel_mux u_mux (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .sel_i(map_q[g / 2][(g % 2) * 8 +: 8]),
         .int_i(int_src_i),
         .pins_i(pins_in),
         .vpin_i(virtual_pin_drive_i),
         .out_o(periph_in_o[g])
      );
   end
endmodule // rmis_top

// file: dv/rmis_src_model.sv
`timescale 1ns/10ps
// ---
// peripheral and pin stand-in
// ---
module rmis_src_model (
   input wire logic flip_i,
   input wire logic quiet_i,
   output rmis_pkg::rmis_pins_s level_o,
   output rmis_pkg::rmis_pins_s dir_o,
   output rmis_pkg::rmis_int_src_s int_o,
   output logic [5:0] vpin_o
);
   // flip inverts every level, so a stuck selector cannot pass
   assign level_o = 34'h25A5AC3C3 ^ {34{flip_i}};
   // one pin left as output: its level must never get through
   assign dir_o = quiet_i ? 34'h000000000 : 34'h3FFFFFFF7;
   assign int_o = quiet_i ? 8'h00 : 8'h96 ^ {8{flip_i}};
   assign vpin_o = quiet_i ? 6'h00 : 6'h25 ^ {6{flip_i}};
endmodule // rmis_src_model

// file: dv/rmis_chk.sv
`timescale 1ns/10ps
// ---
// port checker
// ---
module rmis_chk #(
   parameter int NUM_MAPS = 34
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire rmis_pkg::rmis_pins_s pin_level_i,
   input wire rmis_pkg::rmis_pins_s pin_direction_bits_i,
   input wire rmis_pkg::rmis_int_src_s int_src_i,
   input wire logic [5:0] virtual_pin_drive_i,
   input wire logic [2*NUM_MAPS-1:0] periph_in_o,
   input wire logic map_write_lock_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_take;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_still;
      $stable(pin_level_i) && $stable(pin_direction_bits_i) && $stable(int_src_i) && $stable(virtual_pin_drive_i);
   endsequence
   AST_ACK_NEXT: assert property (s_take |=> ack_o) else $error("no ack");
   AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack too long");
   AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
   AST_RST_CLEAR: assert property (disable iff (1'b0) rst_i |=> !(|periph_in_o) && !map_write_lock_o)
      else $error("reset state wrong");
   AST_LOCK_CAUSE: assert property ($changed(map_write_lock_o) && !$past(rst_i) |-> $past(ack_o && we_i))
      else $error("lock moved without write");
   // outputs may only move after a source change or a bus write
   AST_OUT_STEADY: assert property (s_still and !(cyc_i && stb_i && we_i) && !$past(rst_i) |=> $stable(periph_in_o))
      else $error("output moved alone");
   AST_DIR_GATE: assert property (pin_direction_bits_i == 34'h000000000 && int_src_i == 8'h00
      && virtual_pin_drive_i == 6'h00 |=> !(|periph_in_o)) else $error("output pin got through");
   AST_READ_UPPER: assert property (ack_o && !we_i |-> dat_o[31:16] == 16'h0000) else $error("upper half set");
endmodule // rmis_chk

bind rmis_top rmis_chk #(.NUM_MAPS(NUM_MAPS)) rmis_chk_inst (.*);

// file: dv/tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_total++; \
   $display("FAIL %s exp %0h got %0h", n, e, s); end end
module tb_top;
   logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, flip = 1'b0, quiet = 1'b0;
   logic ack_o, lock_o;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h00000000, dat_o, rd;
   logic [67:0] per_o;
   rmis_pkg::rmis_pins_s lvl, dir;
   rmis_pkg::rmis_int_src_s isrc;
   logic [5:0] vp;
   int err_total = 0, samples_checked = 0;
   initial forever #5 clk_i = ~clk_i;
   rmis_src_model rmis_src_model_inst (.flip_i(flip), .quiet_i(quiet), .level_o(lvl), .dir_o(dir), .int_o(isrc),
      .vpin_o(vp));
   rmis_top rmis_top_inst (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .pin_level_i(lvl), .pin_direction_bits_i(dir),
      .int_src_i(isrc), .virtual_pin_drive_i(vp), .periph_in_o(per_o), .map_write_lock_o(lock_o));
   // ---
   // helpers
   // ---
   task close_out;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task wb(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic w);
      int n;
      {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
      n = 0;
      do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin err_total++; close_out; end
      rd = dat_o;
      {cyc_i, stb_i, we_i} <= 3'b000;
      @(posedge clk_i);
   endtask
   function automatic logic exp_bit(input logic [7:0] c);
      rmis_pkg::rmis_pins_s p;
      p = lvl & dir;
      exp_bit = 1'b0;
      if (c inside {[8'h01:8'h03]}) exp_bit = isrc.cmp[c - 8'h01];
      if (c inside {[8'h06:8'h07]}) exp_bit = isrc.trig[c - 8'h06];
      if (c inside {[8'h0B:8'h0D]}) exp_bit = isrc.pwm_evt[c - 8'h0B];
      if (c inside {[8'h20:8'h2F]}) exp_bit = p.port_b[c - 8'h20];
      if (c inside {[8'h30:8'h3D]}) exp_bit = p.port_c[c - 8'h30];
      if (c inside {[8'hB0:8'hB5]}) exp_bit = vp[c - 8'hB0];
      case (c)
         8'h41: exp_bit = p.port_d[0];
         8'h48: exp_bit = p.port_d[1];
         8'h4A: exp_bit = p.port_d[2];
         8'h4D: exp_bit = p.port_d[3];
         default: ;
      endcase
   endfunction
   // ---
   // scenarios
   // ---
   task t_reset;
      `CHK("periph", 68'h0, per_o)
      wb(8'h88, 32'h0, 4'hF, 1'b0);
      `CHK("lock", 1'b0, rd[11])
      $display("reset test done");
   endtask
   task t_codes;
      logic [7:0] cs [22] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h0A, 8'h0B, 8'h0D, 8'h1F, 8'h20, 8'h2F,
         8'h30, 8'h3D, 8'h3E, 8'h41, 8'h48, 8'h4A, 8'h4D, 8'hB0, 8'hB5, 8'hB6};
      foreach (cs[i]) for (int f = 0; f < 2; f++) begin
         flip <= f[0];
         wb(8'h00, {24'h000000, cs[i]}, 4'h1, 1'b1);
         @(posedge clk_i);
         `CHK("periph0", exp_bit(cs[i]), per_o[0])
      end
      $display("code test done");
   endtask
   task t_field;
      wb(8'h7C, 32'h0000B100, 4'h2, 1'b1);
      wb(8'h7C, 32'h0, 4'hF, 1'b0);
      `CHK("adc trig map", 32'h0000B100, rd)
      `CHK("adc trig", {vp[1], 1'b0}, per_o[63:62])
      wb(8'hFC, 32'h0, 4'hF, 1'b0);
      `CHK("unmapped", 32'h0, rd)
      $display("field test done");
   endtask
   task t_lock;
      wb(8'h88, 32'h00000800, 4'h2, 1'b1);
      @(posedge clk_i);
      `CHK("lock no key", 1'b0, lock_o)
      wb(8'h8C, 32'h55, 4'h1, 1'b1);
      wb(8'h8C, 32'hAA, 4'h1, 1'b1);
      wb(8'h88, 32'h00000800, 4'h2, 1'b1);
      @(posedge clk_i);
      `CHK("lock set", 1'b1, lock_o)
      wb(8'h00, 32'h20, 4'h1, 1'b1);
      wb(8'h00, 32'h0, 4'hF, 1'b0);
      `CHK("locked map", 32'h000000B6, rd)
      wb(8'h8C, 32'h55, 4'h1, 1'b1);
      wb(8'h8C, 32'hAA, 4'h1, 1'b1);
      wb(8'h88, 32'h0, 4'h2, 1'b1);
      @(posedge clk_i);
      `CHK("lock clear", 1'b0, lock_o)
      quiet <= 1'b1;
      repeat (3) @(posedge clk_i);
      `CHK("quiet", 68'h0, per_o)
      $display("lock test done");
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset;
      t_codes;
      t_field;
      t_lock;
      close_out;
   end
endmodule // tb_top
